// ==== src/oufh_pkg.sv ====
package oufh_pkg;

  // command codes of the two settings on the management bus
  localparam logic [7:0] CMD_UV_THRESH = 8'h44;
  localparam logic [7:0] CMD_UV_REACT = 8'h45;

  // field positions inside the reaction byte
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DLY_HI = 2;
  localparam int DLY_LO = 0;

  // response codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_HOLD = 2'h3;

  // retry codes
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // values after reset, and the constant one used by the delay timer
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [7:0] REACT_RST = 8'h00;
  localparam logic [7:0] UNITS_ONE = 8'h01;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_DLY_RUN = 3'b010,
    ST_HOLD = 3'b011,
    ST_OFF_WAIT = 3'b100,
    ST_RESTART = 3'b101,
    ST_ATTEMPT = 3'b110,
    ST_LATCH = 3'b111
  } oufh_state_e;

endpackage

// ==== src/oufh_tmr_if.sv ====
`timescale 1ns/100ps
interface oufh_tmr_if #(
  parameter int UNIT_W = 16
);
  logic start;
  logic [2:0] exp;
  logic [UNIT_W-1:0] unit_len;
  logic done;

  modport ctl (
    output start,
    output exp,
    output unit_len,
    input done
  );

  modport tmr (
    input start,
    input exp,
    input unit_len,
    output done
  );
endinterface

// ==== src/oufh_timer.sv ====
`timescale 1ns/100ps
module oufh_timer
  import oufh_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  oufh_tmr_if.tmr bus
);

  typedef struct packed {
    logic run;
    logic [UNIT_W-1:0] cnt;
    logic [UNIT_W-1:0] len;
    logic [7:0] units;
    logic [7:0] last;
    logic done;
  } oufh_tmr_s;

  oufh_tmr_s s_ff;
  oufh_tmr_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (bus.start) begin
      nxt_s.run = 1'b1;
      nxt_s.cnt = '0;
      nxt_s.units = '0;
      // a zero unit length would wrap round to the longest count, so it counts as one cycle
      nxt_s.len = (bus.unit_len == '0) ? UNIT_W'(1) : bus.unit_len;
      nxt_s.last = (UNITS_ONE << bus.exp) - UNITS_ONE;
    end else if (s_ff.run) begin
      if (s_ff.cnt == s_ff.len - UNIT_W'(1)) begin
        nxt_s.cnt = '0;
        if (s_ff.units == s_ff.last) begin
          nxt_s.run = 1'b0;
          nxt_s.done = 1'b1;
        end else begin
          nxt_s.units = s_ff.units + 8'h01;
        end
      end else begin
        nxt_s.cnt = s_ff.cnt + UNIT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.done = s_ff.done;

endmodule

// ==== src/oufh_handler.sv ====
// Function
// - keep the undervoltage threshold as a 16-bit unsigned output-voltage value
// - response 00: keep running undisturbed on the fault
// - response 01: run for the delay, then retry if fault remains
// - response 10: disable output at once, then follow the retry setting
// - response 11: output off while fault lasts, back on when it ends
// - latched fault clears by status clear, clear-faults, reset, or off-then-on
// - retry 000: no restart, output stays off until the fault is cleared
// - retry 001..110: that many restarts, then stay off until cleared
// - restart attempts are spaced by the delay in fault time units
// - retry 111: retry endlessly until commanded off, reset or other fault
// - delay field gives two to the field value time units
// - same delay serves for run-on time and for restart spacing
// - the length of one time unit comes from outside this block
`timescale 1ns/100ps
module oufh_handler
  import oufh_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_ff,
  output logic reg_ack_ff,
  output logic reg_nak_ff,
  input wire logic [15:0] vout_meas,
  input wire logic [UNIT_W-1:0] delay_unit_cycles,
  input wire logic output_on_cmd,
  input wire logic status_clear,
  input wire logic clear_faults,
  input wire logic other_fault,
  output logic output_enable_ff,
  output logic uv_fault_flag_ff,
  output logic uv_below_ff,
  output logic uv_latched_off_ff,
  output logic [2:0] attempt_count_ff
);

  typedef struct packed {
    oufh_state_e st;
    logic [15:0] thresh;
    logic [7:0] react;
    logic oe;
    logic flt;
    logic uv;
    logic latched;
    logic [2:0] used;
    logic on_d;
    logic tstart;
    logic [15:0] rdata;
    logic ack;
    logic nak;
  } oufh_st_s;

  oufh_st_s s_ff;
  oufh_st_s nxt_s;

  oufh_tmr_if #(.UNIT_W(UNIT_W)) tmr_bus ();

  oufh_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(tmr_bus)
  );

  logic [1:0] resp;
  logic [2:0] retry;
  logic tdone;
  logic on_rise;
  logic clr;

  assign resp = s_ff.react[RESP_HI:RESP_LO];
  assign retry = s_ff.react[RETRY_HI:RETRY_LO];
  // a stale done from an abandoned wait lands before the reload; drop it
  assign tdone = tmr_bus.done && !s_ff.tstart;
  assign on_rise = output_on_cmd && !s_ff.on_d;
  assign clr = status_clear || clear_faults || on_rise;

  assign tmr_bus.start = s_ff.tstart;
  assign tmr_bus.exp = s_ff.react[DLY_HI:DLY_LO];
  assign tmr_bus.unit_len = delay_unit_cycles;

  // shared entry into the retry path
  function automatic oufh_st_s go_retry(input oufh_st_s x,
                                        input logic [2:0] r);
    oufh_st_s y;
    y = x;
    y.oe = 1'b0;
    if (r == RETRY_NONE) begin
      y.st = ST_LATCH;
    end else begin
      y.st = ST_OFF_WAIT;
      y.tstart = 1'b1;
    end
    return y;
  endfunction

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tstart = 1'b0;
    nxt_s.ack = 1'b0;
    nxt_s.nak = 1'b0;
    nxt_s.on_d = output_on_cmd;
    nxt_s.uv = (vout_meas < s_ff.thresh);

    if (reg_wr || reg_rd) begin
      unique case (reg_cmd)
        CMD_UV_THRESH: begin
          nxt_s.ack = 1'b1;
          nxt_s.rdata = s_ff.thresh;
          if (reg_wr) begin
            nxt_s.thresh = reg_wdata;
          end
        end
        CMD_UV_REACT: begin
          nxt_s.ack = 1'b1;
          nxt_s.rdata = {8'h00, s_ff.react};
          if (reg_wr) begin
            nxt_s.react = reg_wdata[7:0];
          end
        end
        default: begin
          nxt_s.nak = 1'b1;
          nxt_s.rdata = 16'h0000;
        end
      endcase
    end

    // sticky status bit; a new detection beats a clear in the same cycle
    if (clr) begin
      nxt_s.flt = 1'b0;
    end
    if (s_ff.uv && s_ff.oe) begin
      nxt_s.flt = 1'b1;
    end

    if (!output_on_cmd) begin
      nxt_s.st = ST_OFF;
      nxt_s.oe = 1'b0;
      nxt_s.used = 3'h0;
    end else if (other_fault) begin
      nxt_s.st = ST_LATCH;
      nxt_s.oe = 1'b0;
    end else begin
      unique case (s_ff.st)
        ST_OFF: begin
          // off then on clears any latched state
          nxt_s.st = ST_RUN;
          nxt_s.oe = 1'b1;
          nxt_s.used = 3'h0;
        end
        ST_RUN: begin
          nxt_s.oe = 1'b1;
          if (s_ff.uv) begin
            unique case (resp)
              RESP_IGNORE: begin
                nxt_s.st = ST_RUN;
              end
              RESP_DELAY: begin
                nxt_s.st = ST_DLY_RUN;
                nxt_s.tstart = 1'b1;
              end
              RESP_DISABLE: begin
                nxt_s = go_retry(nxt_s, retry);
              end
              RESP_HOLD: begin
                nxt_s.st = ST_HOLD;
                nxt_s.oe = 1'b0;
              end
            endcase
          end
        end
        ST_DLY_RUN: begin
          // only the level at the end of the run-on time counts
          if (tdone) begin
            if (s_ff.uv) begin
              nxt_s = go_retry(nxt_s, retry);
            end else begin
              nxt_s.st = ST_RUN;
            end
          end
        end
        ST_HOLD: begin
          // limitation: with the output off, the reading must come back
          // from outside for this state to end
          if (!s_ff.uv) begin
            nxt_s.st = ST_RUN;
            nxt_s.oe = 1'b1;
          end
        end
        ST_OFF_WAIT: begin
          if (tdone) begin
            nxt_s.st = ST_RESTART;
          end
        end
        ST_RESTART: begin
          // one cycle with the output off marks the start of an attempt
          nxt_s.st = ST_ATTEMPT;
          nxt_s.oe = 1'b1;
          nxt_s.tstart = 1'b1;
          if (s_ff.used != RETRY_FOREVER) begin
            nxt_s.used = s_ff.used + 3'h1;
          end
        end
        ST_ATTEMPT: begin
          if (tdone) begin
            if (!s_ff.uv) begin
              nxt_s.st = ST_RUN;
              nxt_s.used = 3'h0;
            end else if (retry == RETRY_FOREVER) begin
              nxt_s.st = ST_RESTART;
              nxt_s.oe = 1'b0;
            end else if (s_ff.used < retry) begin
              nxt_s.st = ST_RESTART;
              nxt_s.oe = 1'b0;
            end else begin
              nxt_s.st = ST_LATCH;
              nxt_s.oe = 1'b0;
            end
          end
        end
        ST_LATCH: begin
          nxt_s.oe = 1'b0;
          if (status_clear || clear_faults) begin
            nxt_s.st = ST_RUN;
            nxt_s.oe = 1'b1;
            nxt_s.used = 3'h0;
          end
        end
      endcase
    end
    nxt_s.latched = (nxt_s.st == ST_LATCH);
  end

  // reset leaves the output off with no fault latched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_ff <= '{st: ST_OFF, thresh: THRESH_RST, react: REACT_RST,
                default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata_ff = s_ff.rdata;
  assign reg_ack_ff = s_ff.ack;
  assign reg_nak_ff = s_ff.nak;
  assign output_enable_ff = s_ff.oe;
  assign uv_fault_flag_ff = s_ff.flt;
  assign uv_below_ff = s_ff.uv;
  assign uv_latched_off_ff = s_ff.latched;
  assign attempt_count_ff = s_ff.used;

endmodule

// ==== tb/oufh_handler_checker.sv ====
`timescale 1ns/100ps
module oufh_chk
  import oufh_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_ack_ff,
  input wire logic reg_nak_ff,
  input wire logic output_on_cmd,
  input wire logic status_clear,
  input wire logic clear_faults,
  input wire logic other_fault,
  input wire logic output_enable_ff,
  input wire logic uv_fault_flag_ff,
  input wire logic uv_below_ff,
  input wire logic uv_latched_off_ff
);
  logic rq;
  logic kn;
  logic keep;
  assign rq = reg_wr | reg_rd;
  assign kn = reg_cmd == CMD_UV_THRESH || reg_cmd == CMD_UV_REACT;
  // no clear and no off request this cycle
  assign keep = !status_clear && !clear_faults && output_on_cmd;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ack; rq && kn |=> reg_ack_ff && !reg_nak_ff; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_nak; rq && !kn |=> reg_nak_ff && !reg_ack_ff; endproperty
  a_nak: assert property (p_nak) else $error("no nak");
  property p_idle; !rq |=> !reg_ack_ff && !reg_nak_ff; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_flag; uv_below_ff && output_enable_ff |=> uv_fault_flag_ff;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_hold;
    // the first cycle back on is an off-then-on clear, so skip it
    uv_fault_flag_ff && keep && $past(output_on_cmd) ##1 output_on_cmd
      |-> uv_fault_flag_ff;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_latch;
    uv_latched_off_ff && keep ##1 output_on_cmd |-> uv_latched_off_ff;
  endproperty
  a_latch: assert property (p_latch) else $error("latch lost");
  property p_off; !output_on_cmd |=> !output_enable_ff; endproperty
  a_off: assert property (p_off) else $error("on while off");
  property p_other; other_fault |=> !output_enable_ff; endproperty
  a_other: assert property (p_other) else $error("other fault");
endmodule
bind oufh_handler oufh_chk u_chk (.clk, .sys_rst, .reg_wr, .reg_rd,
  .reg_cmd, .reg_ack_ff, .reg_nak_ff, .output_on_cmd, .status_clear,
  .clear_faults, .other_fault, .output_enable_ff, .uv_fault_flag_ff,
  .uv_below_ff, .uv_latched_off_ff);

// ==== tb/oufh_host.sv ====
`timescale 1ns/100ps
module oufh_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_cmd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_ff,
  input wire logic reg_ack_ff
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
  end
  // released command and data lines show the inverse, never a stale copy
  task automatic acc(input logic wr, input logic [7:0] c,
    input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_cmd <= c;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_cmd <= ~c;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata_ff;
    ok = reg_ack_ff;
  endtask
endmodule

// ==== tb/test_oufh_handler.sv ====
`timescale 1ns/100ps
module test_oufh_handler
  import oufh_pkg::*;
;
  logic clk = 0, sys_rst = 1, reg_wr, reg_rd, reg_ack_ff, reg_nak_ff;
  logic [7:0] reg_cmd;
  logic [15:0] reg_wdata, reg_rdata_ff, vout_meas = 16'h8000;
  logic [15:0] delay_unit_cycles = 16'h0002;
  logic output_on_cmd = 0, status_clear = 0, clear_faults = 0;
  logic other_fault = 0, output_enable_ff, uv_fault_flag_ff;
  logic uv_below_ff, uv_latched_off_ff;
  logic [2:0] attempt_count_ff;
  int mismatches = 0, samples_checked = 0, n, gap;
  always #20 clk = ~clk;
  oufh_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_ack_ff(reg_ack_ff));
  oufh_handler #(.UNIT_W(16)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_ack_ff(reg_ack_ff), .reg_nak_ff(reg_nak_ff),
    .vout_meas(vout_meas), .delay_unit_cycles(delay_unit_cycles),
    .output_on_cmd(output_on_cmd), .status_clear(status_clear),
    .clear_faults(clear_faults), .other_fault(other_fault),
    .output_enable_ff(output_enable_ff),
    .uv_fault_flag_ff(uv_fault_flag_ff), .uv_below_ff(uv_below_ff),
    .uv_latched_off_ff(uv_latched_off_ff),
    .attempt_count_ff(attempt_count_ff));
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task rw(input logic w, input logic [7:0] c, input logic [15:0] d,
    input logic [15:0] e, input logic eok);
    logic [15:0] q;
    logic ok;
    u_host.acc(w, c, d, q, ok);
    chk({15'h0, ok}, {15'h0, eok});
    if (!w)
      chk(q, e);
  endtask
  task sv(input logic [15:0] v);
    @(posedge clk) vout_meas <= v;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task woe(input logic v);
    int i;
    for (i = 0; i < 10 && output_enable_ff !== v; i++)
      cyc(1);
    chk({15'h0, output_enable_ff}, {15'h0, v});
  endtask
  // counts rising edges of the output until latched or bound runs out
  task rtr;
    int i, t0;
    logic p;
    n = 0;
    gap = 0;
    t0 = 0;
    p = 1;
    for (i = 0; i < 400 && uv_latched_off_ff !== 1'b1; i++) begin
      cyc(1);
      if (output_enable_ff === 1'b1 && p === 1'b0) begin
        n++;
        if (n == 2)
          gap = i - t0;
        t0 = i;
      end
      p = output_enable_ff;
    end
  endtask
  initial begin
    #400000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    rw(0, 8'h44, 0, 16'h0000, 1);
    rw(0, 8'h45, 0, 16'h0000, 1);
    rw(0, 8'h46, 0, 16'h0000, 0);
    rw(1, 8'h44, 16'h1000, 0, 1);
    rw(0, 8'h44, 0, 16'h1000, 1);
    rw(1, 8'h45, 16'hFFFF, 0, 1);
    rw(0, 8'h45, 0, 16'h00FF, 1);
    rw(1, 8'h45, 16'h0000, 0, 1);
    @(posedge clk) output_on_cmd <= 1;
    woe(1);
    sv(16'h0FFF);
    cyc(20);
    chk({15'h0, output_enable_ff}, 16'h1);
    chk({15'h0, uv_fault_flag_ff}, 16'h1);
    sv(16'h1000);
    @(posedge clk) clear_faults <= 1;
    @(posedge clk) clear_faults <= 0;
    cyc(2);
    chk({15'h0, uv_fault_flag_ff}, 16'h0);
    rw(1, 8'h45, 16'h0080, 0, 1);
    sv(16'h0FFF);
    woe(0);
    sv(16'h8000);
    cyc(20);
    chk({15'h0, output_enable_ff}, 16'h0);
    @(posedge clk) status_clear <= 1;
    @(posedge clk) status_clear <= 0;
    woe(1);
    rw(1, 8'h45, 16'h00C0, 0, 1);
    sv(16'h0FFF);
    woe(0);
    sv(16'h8000);
    woe(1);
    rw(1, 8'h45, 16'h0051, 0, 1);
    sv(16'h0FFF);
    cyc(3);
    chk({15'h0, output_enable_ff}, 16'h1);
    rtr;
    chk(n[15:0], 16'h2);
    chk({15'h0, gap >= 4 && gap <= 16}, 16'h1);
    chk({13'h0, attempt_count_ff}, 16'h2);
    sv(16'h8000);
    @(posedge clk) output_on_cmd <= 0;
    @(posedge clk) output_on_cmd <= 1;
    cyc(3);
    chk({15'h0, uv_latched_off_ff}, 16'h0);
    rw(1, 8'h45, 16'h0079, 0, 1);
    sv(16'h0FFF);
    rtr;
    chk({15'h0, n > 7}, 16'h1);
    chk({13'h0, attempt_count_ff}, 16'h7);
    @(posedge clk) other_fault <= 1;
    cyc(3);
    chk({15'h0, uv_latched_off_ff}, 16'h1);
    @(posedge clk) other_fault <= 0;
    output_on_cmd <= 0;
    cyc(3);
    chk({13'h0, attempt_count_ff}, 16'h0);
    end_sim;
  end
endmodule
